// ===== logic/tws_pkg.sv
// Purpose: constants and carriers for the three-wire control port register block
// Assumes: register addresses are 7 bits, register words are 16 bits
// Notes: rule summary below; tags in the module point back to it
//
// What this block does
// - a read is six bytes: two setup, device address again, three returned
// - first returned byte is flag then address; flag 0 valid, 1 invalid
// - then two data bytes, D15..D8 first, then D7..D0
// - each byte bit 0 first in time; address bytes in address mode
// - field layout of registers 00H, 10H, 11H and 40H with their resets
// - a write is device address, register byte with flag 0, two data bytes
// - mode line low with eight clocks is address mode, high is data mode
// - writing 7FH restores every control value to its default

`default_nettype none

package tws_pkg;

  // register addresses
  localparam logic [6:0] ADDR_SYS = 7'h00;
  localparam logic [6:0] ADDR_SOUND = 7'h10;
  localparam logic [6:0] ADDR_VOL = 7'h11;
  localparam logic [6:0] ADDR_INTERP = 7'h18;
  localparam logic [6:0] ADDR_LOCK = 7'h38;
  localparam logic [6:0] ADDR_MUX = 7'h40;
  localparam logic [6:0] ADDR_RESTORE = 7'h7F;

  // values after reset or restore
  localparam logic [15:0] RST_SYS = 16'h2040;
  localparam logic [15:0] RST_SOUND = 16'h0001;
  localparam logic [15:0] RST_VOL = 16'h0000;
  localparam logic [15:0] RST_MUX = 16'h0002;

  // transfer type bits, bit 0 then bit 1 of the address byte
  localparam logic [1:0] XFER_WRITE = 2'h1;
  localparam logic [1:0] XFER_READ = 2'h3;

  // frame counts
  localparam logic [2:0] BITS_LAST = 3'h7;
  localparam logic [1:0] BYTES_DATA = 2'h3;
  localparam int TX_BITS = 24;

  // control fields handed to the sound path
  typedef struct packed {
    logic dac_power_on;
    logic [1:0] filter_mode;
    logic [3:0] bass_level;
    logic [1:0] treble_level;
    logic [1:0] deemph_sel;
    logic soft_mute;
    logic [5:0] volume;
    logic lock_loss_mute_en;
    logic pll_reset;
  } tws_cfg_s;

  // status gathered from the rest of the chip
  typedef struct packed {
    logic interp_mute_flag;
    logic pll_locked;
    logic input_decoder_locked;
    logic [1:0] sample_rate_code;
    logic pcm_absent;
    logic pre_emphasis;
    logic [1:0] clock_accuracy;
  } tws_stat_s;

  typedef enum logic [1:0] {SEL_NONE, SEL_WRITE, SEL_READ} tws_sel_e;

endpackage

`default_nettype wire

// ===== logic/tws_port.sv
// Purpose: device end of the three-wire control port with its register file
// Assumes: bus lines are asynchronous and far slower than clk_sys_i
// Notes: bus bits are taken on the rising edge of the bus clock as seen here

`timescale 1ns/1ps
`default_nettype none

module tws_port #(
  parameter logic [5:0] DEV_ADDR = 6'h18 // bits 2..7 in time order
) (
  // system
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // three-wire bus
  input wire logic ctl_clock_line_i,
  input wire logic ctl_mode_line_i,
  input wire logic ctl_data_line_i,
  output logic ctl_data_line_o,
  output logic ctl_data_line_oe_o,
  // chip side
  input wire tws_pkg::tws_stat_s stat_i,
  output tws_pkg::tws_cfg_s cfg_o
);

  ////////////////////////////////////////////////////////////////////
  // input synchronisers; the first stage feeds only the second
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic clk_prev_r;
  logic mode_prev_r;

  // reset to the idle levels (clock and mode high) so release shows no false edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= 3'h6;
      sync_r <= 3'h6;
      clk_prev_r <= 1'b1;
      mode_prev_r <= 1'b1;
    end else begin
      meta_r <= {ctl_clock_line_i, ctl_mode_line_i, ctl_data_line_i};
      sync_r <= meta_r;
      clk_prev_r <= sync_r[2];
      mode_prev_r <= sync_r[1];
    end
  end

  wire logic bclk_s = sync_r[2];
  wire logic mode_s = sync_r[1];
  wire logic din_s = sync_r[0];
  wire logic bit_rise = bclk_s & ~clk_prev_r;
  wire logic mode_flip = mode_s ^ mode_prev_r;

  ////////////////////////////////////////////////////////////////////
  // bit and byte framing
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] byte_idx_r;
  tws_pkg::tws_sel_e sel_r;

  // first bit in time ends up in shift_nxt[7]
  wire logic [7:0] shift_nxt = {shift_r[6:0], din_s};
  wire logic byte_done = bit_rise & (bit_cnt_r == tws_pkg::BITS_LAST);
  wire logic addr_done = byte_done & ~mode_s;
  wire logic data_done = byte_done & mode_s & (byte_idx_r != tws_pkg::BYTES_DATA);
  wire logic [1:0] xfer_bits = {shift_nxt[7], shift_nxt[6]};
  wire logic addr_hit = (shift_nxt[5:0] == DEV_ADDR);

  // selection after each address byte; a mismatch drops the frame
  wire tws_pkg::tws_sel_e sel_nxt =
    !addr_hit ? tws_pkg::SEL_NONE :
    (xfer_bits == tws_pkg::XFER_WRITE) ? tws_pkg::SEL_WRITE :
    (xfer_bits == tws_pkg::XFER_READ) ? tws_pkg::SEL_READ : tws_pkg::SEL_NONE;

  // a mode change restarts the bit count so a half byte cannot skew framing
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      byte_idx_r <= 2'h0;
      sel_r <= tws_pkg::SEL_NONE;
    end else begin
      if (mode_flip) begin
        bit_cnt_r <= 3'h0;
      end else if (bit_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r <= shift_nxt;
      end
      if (addr_done) begin
        sel_r <= sel_nxt;
        byte_idx_r <= 2'h0;
      end else if (data_done) begin
        byte_idx_r <= byte_idx_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write path: register byte, then high and low data bytes
  logic [6:0] wr_addr_r;
  logic wr_go_r;
  logic [7:0] wr_hi_r;
  logic [6:0] rd_addr_r;

  wire logic in_write = (sel_r == tws_pkg::SEL_WRITE);
  wire logic reg_byte = data_done & in_write & (byte_idx_r == 2'h0);
  wire logic hi_byte = data_done & in_write & (byte_idx_r == 2'h1);
  wire logic commit = data_done & in_write & (byte_idx_r == 2'h2) & wr_go_r;
  wire logic [15:0] wr_word = {wr_hi_r, shift_nxt};

  // first bit of the register byte picks write (0) or prepare-read (1)
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_addr_r <= 7'h00;
      wr_go_r <= 1'b0;
      wr_hi_r <= 8'h00;
      rd_addr_r <= tws_pkg::ADDR_RESTORE;
    end else begin
      if (reg_byte) begin
        wr_addr_r <= shift_nxt[6:0];
        wr_go_r <= ~shift_nxt[7];
        if (shift_nxt[7]) begin
          rd_addr_r <= shift_nxt[6:0];
        end
      end else if (addr_done) begin
        wr_go_r <= 1'b0;
      end
      if (hi_byte) begin
        wr_hi_r <= shift_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers; restore touches only these, not the status side
  logic [15:0] sys_r;
  logic [15:0] sound_r;
  logic [15:0] vol_r;
  logic [15:0] mux_r;

  wire logic restore = commit & (wr_addr_r == tws_pkg::ADDR_RESTORE);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || restore) begin
      sys_r <= tws_pkg::RST_SYS;
      sound_r <= tws_pkg::RST_SOUND;
      vol_r <= tws_pkg::RST_VOL;
      mux_r <= tws_pkg::RST_MUX;
    end else if (commit) begin
      if (wr_addr_r == tws_pkg::ADDR_SYS) sys_r <= wr_word;
      if (wr_addr_r == tws_pkg::ADDR_SOUND) sound_r <= wr_word;
      if (wr_addr_r == tws_pkg::ADDR_VOL) vol_r <= wr_word;
      if (wr_addr_r == tws_pkg::ADDR_MUX) mux_r <= wr_word;
    end
  end

  // field placement toward the sound path
  assign cfg_o = '{
    dac_power_on: sys_r[13],
    filter_mode: sound_r[13:12],
    bass_level: sound_r[11:8],
    treble_level: sound_r[4:3],
    deemph_sel: sound_r[2:1],
    soft_mute: sound_r[0],
    volume: vol_r[5:0],
    lock_loss_mute_en: mux_r[1],
    pll_reset: mux_r[0]
  };

  ////////////////////////////////////////////////////////////////////
  // read path: flag and address byte, then the 16-bit word
  wire logic [15:0] stat_word = {5'h00, stat_i.pll_locked, 1'b0,
    stat_i.input_decoder_locked, stat_i.sample_rate_code, stat_i.pcm_absent, 1'b0,
    stat_i.pre_emphasis, 1'b0, stat_i.clock_accuracy};
  wire logic rd_valid = (rd_addr_r == tws_pkg::ADDR_SYS) || (rd_addr_r == tws_pkg::ADDR_SOUND)
    || (rd_addr_r == tws_pkg::ADDR_VOL) || (rd_addr_r == tws_pkg::ADDR_INTERP)
    || (rd_addr_r == tws_pkg::ADDR_LOCK) || (rd_addr_r == tws_pkg::ADDR_MUX);
  wire logic [15:0] rd_word =
    (rd_addr_r == tws_pkg::ADDR_SYS) ? sys_r :
    (rd_addr_r == tws_pkg::ADDR_SOUND) ? sound_r :
    (rd_addr_r == tws_pkg::ADDR_VOL) ? vol_r :
    (rd_addr_r == tws_pkg::ADDR_MUX) ? mux_r :
    (rd_addr_r == tws_pkg::ADDR_INTERP) ? {15'h0000, stat_i.interp_mute_flag} :
    (rd_addr_r == tws_pkg::ADDR_LOCK) ? stat_word : 16'h0000;
  wire logic rd_load = addr_done & (sel_nxt == tws_pkg::SEL_READ);
  wire logic [23:0] tx_load = {~rd_valid, rd_addr_r, rd_word};

  logic [23:0] tx_r;

  // loaded at the read address byte; advances after the host takes each bit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_r <= 24'h000000;
    end else if (rd_load) begin
      tx_r <= tx_load;
    end else if (bit_rise & mode_s & (sel_r == tws_pkg::SEL_READ)) begin
      tx_r <= {tx_r[22:0], 1'b0};
    end
  end

  // drive only in data mode of a read frame, releasing after three bytes
  assign ctl_data_line_o = tx_r[23];
  assign ctl_data_line_oe_o = (sel_r == tws_pkg::SEL_READ) & mode_s
    & (byte_idx_r != tws_pkg::BYTES_DATA);

  ////////////////////////////////////////////////////////////////////
  // checks
  a_restore_defaults: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    restore |=> (sys_r == tws_pkg::RST_SYS) && (mux_r == tws_pkg::RST_MUX)
      && (sound_r == tws_pkg::RST_SOUND) && (vol_r == tws_pkg::RST_VOL))
    else $error("restore did not bring back control defaults");

  a_drive_read_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctl_data_line_oe_o |-> (sel_r == tws_pkg::SEL_READ) && mode_s)
    else $error("data line driven outside a read frame");

  a_flag_marks_valid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_load |=> (tx_r[23] == !$past(rd_valid)) && (tx_r[22:16] == $past(rd_addr_r)))
    else $error("returned flag or address wrong");

  a_word_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_load |=> tx_r[15:0] == $past(rd_word))
    else $error("returned word not high byte first");

  a_byte_eight_bits: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (addr_done || data_done) |-> bit_rise && (bit_cnt_r == 3'h7))
    else $error("byte closed before eight clocks");

  // an unselected frame must leave controls, the read pointer and the return word alone
  a_foreign_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (sel_r == tws_pkg::SEL_NONE) && !addr_done |=> $stable(cfg_o) && $stable(rd_addr_r)
      && $stable(tx_r))
    else $error("unselected frame had effect");

  a_write_third_byte: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    commit |-> in_write && (byte_idx_r == 2'h2) && wr_go_r)
    else $error("write committed at wrong byte");

  a_bit_first_msb: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bit_rise && !mode_flip) |=> shift_r[0] == $past(din_s))
    else $error("bit not shifted in time order");

  a_field_power: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (commit && wr_addr_r == tws_pkg::ADDR_SYS) |=> cfg_o.dac_power_on == $past(wr_hi_r[5]))
    else $error("power-on field misplaced");

endmodule

`default_nettype wire

// ===== bench/tws_host.sv
// Purpose: host end of the three-wire control bus
// Assumes: bus clock idles high, 64 ns period made from 4+4 system cycles
// Notes: bytes go out first bit in time first, as the design pairs them

`timescale 1ns/1ps
`default_nettype none

module tws_host #(
  parameter logic [5:0] DEV_ADDR = 6'h18
) (
  // system
  input wire logic clk_sys_i,
  // three-wire bus
  input wire logic data_wire_i,
  output logic clk_line_o,
  output logic mode_line_o,
  output logic data_line_o
);
  // idle bus: clock still and high between frames
  initial begin
    clk_line_o = 1'b1;
    mode_line_o = 1'b1;
    data_line_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one bit: set while clock low, both ends sample at the rise
  task automatic bit_io(input logic b, input logic rel, output logic s);
    @(posedge clk_sys_i);
    clk_line_o <= 1'b0;
    data_line_o <= rel ? ~data_line_o : b; // released line must not hold its level
    repeat (4) @(posedge clk_sys_i);
    s = data_wire_i;
    clk_line_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // mode moves only while the clock idles high
  task automatic byte_io(input logic mode, input logic [7:0] v, input logic rel,
                         output logic [7:0] r);
    @(posedge clk_sys_i);
    mode_line_o <= mode;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], rel, r[i]);
    end
  endtask

  // four-byte write with any address byte
  task automatic xfer_write(input logic [7:0] adr, input logic [6:0] a, input logic [15:0] d);
    logic [7:0] r;
    byte_io(1'b0, adr, 1'b0, r);
    byte_io(1'b1, {1'b0, a}, 1'b0, r);
    byte_io(1'b1, d[15:8], 1'b0, r);
    byte_io(1'b1, d[7:0], 1'b0, r);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // six-byte read: prepare, then device returns flag, address, data
  task automatic xfer_read(input logic [6:0] a, output logic [23:0] q);
    logic [7:0] r;
    byte_io(1'b0, {tws_pkg::XFER_WRITE, DEV_ADDR}, 1'b0, r);
    byte_io(1'b1, {1'b1, a}, 1'b0, r);
    byte_io(1'b0, {tws_pkg::XFER_READ, DEV_ADDR}, 1'b0, r);
    byte_io(1'b1, 8'h00, 1'b1, q[23:16]);
    byte_io(1'b1, 8'h00, 1'b1, q[15:8]);
    byte_io(1'b1, 8'h00, 1'b1, q[7:0]);
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

`default_nettype wire

// ===== bench/test_three_wire_control_port_regs.sv
// Purpose: self-checking bench for the control port register block
// Assumes: one status pattern held steady through the run
// Notes: expected words built from the field layout, never from outputs

`timescale 1ns/1ps
`default_nettype none

module test_three_wire_control_port_regs;
  localparam logic [5:0] DEV = 6'h18;
  logic clk_sys_i, rst_i, clk_line, mode_line, host_d, dev_d, dev_oe;
  wire logic data_wire;
  tws_pkg::tws_stat_s stat;
  tws_pkg::tws_cfg_s cfg, dflt;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [23:0] q;
  logic [6:0] wa [4] = '{7'h00, 7'h10, 7'h11, 7'h40};
  logic [15:0] wd [4] = '{16'h0040, 16'h2A1F, 16'h0025, 16'h0001};

  // the device wins the data line while it drives it
  assign data_wire = dev_oe ? dev_d : host_d;

  tws_port #(.DEV_ADDR(DEV)) u_tws_port (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ctl_clock_line_i(clk_line), .ctl_mode_line_i(mode_line), .ctl_data_line_i(data_wire),
    .ctl_data_line_o(dev_d), .ctl_data_line_oe_o(dev_oe), .stat_i(stat), .cfg_o(cfg));
  tws_host #(.DEV_ADDR(DEV)) u_tws_host (.clk_sys_i(clk_sys_i), .data_wire_i(data_wire),
    .clk_line_o(clk_line), .mode_line_o(mode_line), .data_line_o(host_d));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  // control fields as the register layout places them
  function automatic tws_pkg::tws_cfg_s cfg_of(input logic [15:0] s, input logic [15:0] f,
                                               input logic [15:0] v, input logic [15:0] m);
    return {s[13], f[13:12], f[11:8], f[4:3], f[2:1], f[0], v[5:0], m[1], m[0]};
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_tws_host.xfer_write({tws_pkg::XFER_WRITE, DEV}, a, d);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'b1;
    stat = 9'h1A9;
    dflt = cfg_of(tws_pkg::RST_SYS, tws_pkg::RST_SOUND, tws_pkg::RST_VOL, tws_pkg::RST_MUX);
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    check("cfg after reset", 24'(cfg), 24'(dflt));
    u_tws_host.bit_io(1'b0, 1'b0, q[0]);
    wr(7'h40, 16'h0003);
    check("cfg after init", 24'(cfg), 24'(cfg_of(tws_pkg::RST_SYS, tws_pkg::RST_SOUND,
          tws_pkg::RST_VOL, 16'h0003)));
    wr(7'h7F, 16'h0000);
    check("cfg after restore", 24'(cfg), 24'(dflt));
    for (int i = 0; i < 4; i++) begin
      wr(wa[i], wd[i]);
    end
    check("cfg after writes", 24'(cfg), 24'(cfg_of(wd[0], wd[1], wd[2], wd[3])));
    for (int i = 0; i < 4; i++) begin
      u_tws_host.xfer_read(wa[i], q);
      check("read control", q, {1'b0, wa[i], wd[i]});
    end
    u_tws_host.xfer_read(7'h18, q);
    check("read mute flag", q, {8'h18, 15'h0000, stat.interp_mute_flag});
    u_tws_host.xfer_read(7'h38, q);
    check("read lock", q, {8'h38, 5'h00, stat.pll_locked, 1'b0, stat.input_decoder_locked,
          stat.sample_rate_code, stat.pcm_absent, 1'b0, stat.pre_emphasis, 1'b0,
          stat.clock_accuracy});
    u_tws_host.xfer_read(7'h05, q);
    check("read invalid", q, {1'b1, 7'h05, 16'h0000});
    check("data line released", {23'h000000, dev_oe}, 24'h000000);
    // foreign device, both unused transfer types and a read-only target change nothing
    u_tws_host.xfer_write({tws_pkg::XFER_WRITE, DEV ^ 6'h01}, 7'h11, 16'h003F);
    u_tws_host.xfer_write({2'h0, DEV}, 7'h11, 16'h003F);
    u_tws_host.xfer_write({2'h2, DEV}, 7'h11, 16'h003F);
    wr(7'h18, 16'hFFFF);
    check("cfg after refused", 24'(cfg), 24'(cfg_of(wd[0], wd[1], wd[2], wd[3])));
    wr(7'h7F, 16'h1234);
    check("cfg after second restore", 24'(cfg), 24'(dflt));
    summarize();
  end
endmodule

`default_nettype wire
